// [sipo_latch_map.vh]
/*
 * Constants for the serial-in, parallel-out latch: widths, reset values,
 * fifo sizing.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef SIPO_LATCH_MAP_VH
`define SIPO_LATCH_MAP_VH
`define STAGE_COUNT 8
`define SHIFT_RESET 8'h00
`define STORE_RESET 8'h00
`define FIFO_DEPTH 32
`endif

// [serial_in_parallel_out_latch.v]
/*
 * Serial-in, parallel-out shift register feeding a storage register with
 * three-state parallel outputs and a cascade output; a small fifo carries
 * shifted bytes toward the storage register.
 * Assumes all host pins are asynchronous to core_clk and pulse no faster
 * than about three core_clk periods per level.
 */
// Contract
// - eight-stage shift register feeds an eight-bit storage register.
// - storage register drives eight three-state parallel outputs.
// - shift and storage clocks are independent, both rising-edge acting.
// - drive_enable_n high tri-states parallel outputs; chain output always driven.
// - shift_clear_n low clears all shift stages at once, overriding shifting.
// - shift_clock rising edge loads bit_input into stage one, shifts others up.
// - shift_clock falling edge changes nothing.
// - latch_clock rising edge copies all stages into storage register.
// - latch_clock falling edge changes nothing.
// - with tied clocks, storage takes pre-edge shift contents, lagging one pulse.
// - last stage appears on chain_output for cascading devices.
`timescale 1ns/1ps
`include "sipo_latch_map.vh"

module sync2 (
   input wire clk,
   input wire resetn,
   input wire d,
   output reg q
);
   reg m_q;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         m_q <= 1'b0;
         q <= 1'b0;
      end else begin
         m_q <= d;
         q <= m_q;
      end
   end
endmodule

module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire clk,
   input wire resetn,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   // sized copy so the full compare can slice the depth to the AW+1 bit count width
   localparam [31:0] DEPTH_W = DEPTH;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_q != DEPTH_W[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem[rd_q];
   always @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
         end else if (pop && !push) begin
            cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule

module serial_in_parallel_out_latch #(
   parameter STAGES = `STAGE_COUNT,
   parameter DEPTH = `FIFO_DEPTH
) (
   // core
   input wire core_clk,
   input wire resetn,
   // host pins
   input wire bit_input,
   input wire shift_clock,
   input wire shift_clear_n,
   input wire latch_clock,
   input wire drive_enable_n,
   // outputs
   output reg [STAGES-1:0] parallel_outputs,
   output reg [STAGES-1:0] parallel_outputs_oe,
   output reg chain_output
);
   wire bit_s, sclk_s, clr_n_s, lclk_s, oe_n_s;
   reg sclk_prev_q, lclk_prev_q;
   reg [STAGES-1:0] shift_q;
   reg [STAGES-1:0] store_q;
   wire fifo_in_ready, fifo_out_valid;
   wire [STAGES-1:0] fifo_out_data;

   sync2 u_s_bit (.clk(core_clk), .resetn(resetn), .d(bit_input), .q(bit_s));
   sync2 u_s_sclk (.clk(core_clk), .resetn(resetn), .d(shift_clock), .q(sclk_s));
   sync2 u_s_clr (.clk(core_clk), .resetn(resetn), .d(shift_clear_n), .q(clr_n_s));
   sync2 u_s_lclk (.clk(core_clk), .resetn(resetn), .d(latch_clock), .q(lclk_s));
   sync2 u_s_oe (.clk(core_clk), .resetn(resetn), .d(drive_enable_n), .q(oe_n_s));

   // edges found on synchronised copies only
   wire sclk_rise = sclk_s && !sclk_prev_q;
   wire lclk_rise = lclk_s && !lclk_prev_q;

   // each latch edge pushes the pre-edge shift contents; fifo then drains
   // into the storage register, so a tied-clock edge still sees old data
   byte_fifo #(.WIDTH(STAGES), .DEPTH(DEPTH), .AW(5)) u_fifo (
      .clk(core_clk),
      .resetn(resetn),
      .in_valid(lclk_rise),
      .in_ready(fifo_in_ready),
      .in_data(shift_q),
      .out_valid(fifo_out_valid),
      .out_ready(1'b1),
      .out_data(fifo_out_data)
   );

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sclk_prev_q <= 1'b0;
         lclk_prev_q <= 1'b0;
         shift_q <= `SHIFT_RESET;
         store_q <= `STORE_RESET;
         parallel_outputs <= `STORE_RESET;
         parallel_outputs_oe <= {STAGES{1'b0}};
         chain_output <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
         lclk_prev_q <= lclk_s;
         if (!clr_n_s) begin
            shift_q <= `SHIFT_RESET;
         end else if (sclk_rise) begin
            shift_q <= {shift_q[STAGES-2:0], bit_s};
         end
         if (fifo_out_valid) begin
            store_q <= fifo_out_data;
         end
         parallel_outputs <= store_q;
         parallel_outputs_oe <= {STAGES{~oe_n_s}};
         // chain always driven, no enable
         chain_output <= shift_q[STAGES-1];
      end
   end
endmodule

// [sipo_props.sv]
/* port checker for the latch
   assumes host pins hold each level several core_clk */
`timescale 1ns/1ps
module sipo_props #(parameter STAGES = 8) (
   input wire core_clk, resetn, shift_clock, shift_clear_n, latch_clock, drive_enable_n,
   input wire [STAGES-1:0] parallel_outputs, parallel_outputs_oe,
   input wire chain_output);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   property p_on; !drive_enable_n[*5] |-> &parallel_outputs_oe; endproperty
   a_on: assert property (p_on) else $error("oe on");
   property p_off; drive_enable_n[*5] |-> !parallel_outputs_oe; endproperty
   a_off: assert property (p_off) else $error("oe off");
   property p_clr; !shift_clear_n[*8] |-> !chain_output; endproperty
   a_clr: assert property (p_clr) else $error("clr");
   property p_clf; $fell(shift_clear_n) |-> ##[1:8] !chain_output; endproperty
   a_clf: assert property (p_clf) else $error("clr late");
   property p_sh; (shift_clear_n && $stable(shift_clock))[*8] |=> $stable(chain_output); endproperty
   a_sh: assert property (p_sh) else $error("chain");
   property p_sf; $fell(shift_clock) |-> $stable(chain_output)[*6]; endproperty
   a_sf: assert property (p_sf) else $error("chain fall");
   property p_lh; $stable(latch_clock)[*8] |=> $stable(parallel_outputs); endproperty
   a_lh: assert property (p_lh) else $error("store");
   property p_lf; $fell(latch_clock) |-> $stable(parallel_outputs)[*6]; endproperty
   a_lf: assert property (p_lf) else $error("store fall");
endmodule
bind serial_in_parallel_out_latch sipo_props #(.STAGES(STAGES)) sipo_props_inst (.*);

// [host_pins.sv]
/* host model: msb first on a 125 ns shift clock
   assumes the bench owns clear and enable */
`timescale 1ns/1ps
module host_pins (output reg bit_input = 0, output reg shift_clock = 0,
   output reg latch_clock = 0);
   task send(input [7:0] b, input t);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            bit_input = b[i];
            #62.5 shift_clock = 1;
            latch_clock = t;
            #62.5 shift_clock = 0;
            latch_clock = 0;
         end
         bit_input = ~bit_input; // stale data not held
         #62.5 latch_clock = !t;
         #62.5 latch_clock = 0;
      end
   endtask
endmodule

// [serial_in_parallel_out_latch_test.sv]
/* latch bench
   assumes output latency of a few core_clk */
`timescale 1ns/1ps
module serial_in_parallel_out_latch_test;
   reg core_clk = 0, resetn = 0, shift_clear_n = 1, drive_enable_n = 0;
   wire bit_input, shift_clock, latch_clock, chain_output;
   wire [7:0] parallel_outputs, parallel_outputs_oe;
   wire [7:0] q = parallel_outputs_oe[0] ? parallel_outputs : 8'hzz;
   integer failures = 0, total_checks = 0;
   host_pins host_pins_inst (.*);
   serial_in_parallel_out_latch serial_in_parallel_out_latch_inst (.*);
   task chk(input [63:0] n, input [7:0] e, g);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("MISMATCH %0s expected %h seen %h", n, e, g);
         end
      end
   endtask
   task idle; repeat (20) @(negedge core_clk); endtask
   task run(input [7:0] b, input t); begin host_pins_inst.send(b, t); idle; end endtask
   task t_load;
      begin
         run(8'ha5, 0);
         chk("load", 8'ha5, q);
         chk("chain", 8'h01, {7'h0, chain_output});
      end
   endtask
   task t_oe;
      begin
         drive_enable_n = 1;
         idle;
         chk("float", 8'hzz, q);
         chk("chain", 8'h01, {7'h0, chain_output});
         drive_enable_n = 0;
         idle;
         chk("drive", 8'ha5, q);
      end
   endtask
   task t_tied;
      begin
         run(8'h3c, 0);
         run(8'hc3, 1);
         chk("tied", 8'h61, q);
      end
   endtask
   task t_clear;
      begin
         shift_clear_n = 0;
         idle;
         chk("cleared", 8'h00, {7'h0, chain_output});
         run(8'hff, 0);
         chk("blocked", 8'h00, q);
         shift_clear_n = 1;
      end
   endtask
   task conclude;
      begin
         $display("checks %0d failures %0d", total_checks, failures);
         if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial forever #2 core_clk = ~core_clk;
   initial begin
      repeat (2) @(negedge core_clk);
      resetn = 1;
      idle;
      t_load;
      t_oe;
      t_tied;
      t_clear;
      conclude;
   end
   initial begin
      #40000 failures = failures + 1;
      conclude;
   end
endmodule
